// ==== timer_pkg.sv ====
// Purpose: Shared constants for the auto-reload timer with capture.
// Assumes: 8-bit special function register bus, 40 MHz system clock.
// Notes:   Offsets are the register addresses on that bus.
`default_nettype none
package timer_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ctrl_offset      = 8'hC8;
   localparam logic [7:0] reload_lo_offset = 8'hCA;
   localparam logic [7:0] reload_hi_offset = 8'hCB;
   localparam logic [7:0] count_lo_offset  = 8'hCC;
   localparam logic [7:0] count_hi_offset  = 8'hCD;
   localparam logic [7:0] clkctl_offset    = 8'h8E;
   // ------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------
   localparam int hi_flag_bit    = 7;
   localparam int lo_flag_bit    = 6;
   localparam int lo_irq_en_bit  = 5;
   localparam int capture_en_bit = 4;
   localparam int split_bit      = 3;
   localparam int run_bit        = 2;
   localparam int ext_sel_bit    = 0;
   localparam int hi_sys_bit     = 5;
   localparam int lo_sys_bit     = 4;
   localparam logic [7:0] ctrl_reset   = 8'h00;
   localparam logic [7:0] reload_reset = 8'h00;
   localparam logic [7:0] ctrl_wmask   = 8'hFD;
   localparam logic [7:0] clkctl_wmask = 8'h30;
   // ------------------------------------------------------------
   // Dividers
   // ------------------------------------------------------------
   localparam int sys_div   = 12;
   localparam int ext_div   = 8;
   localparam int sync_len  = 2;
endpackage
`default_nettype wire

// ==== tick_divider.sv ====
// Purpose: Divides the system clock to a one-cycle enable pulse.
// Assumes: Single clock domain.
// Notes:   Pulse fires once every DIV cycles.
`timescale 1ns/1ps
`default_nettype none
module tick_divider
#(
   parameter int DIV = 12
)
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Tick
   output var  logic tick
);
   localparam int W = $clog2(DIV);
   localparam logic [W-1:0] last = W'(DIV - 1);
   logic [W-1:0] cnt_q;
   wire at_end = (cnt_q == last);
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end
      else
      begin
         cnt_q <= at_end ? '0 : cnt_q + 1'b1;
         tick  <= at_end;
      end
   end
endmodule // tick_divider
`default_nettype wire

// ==== ext_clock_sync.sv ====
// Purpose: Synchronises the divided external clock and finds its edges.
// Assumes: External clock divided by 8 arrives as a level input.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module ext_clock_sync
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // External level
   input  wire logic ext_level,
   // Edges in the system domain
   output var  logic rise,
   output var  logic fall
);
   logic meta_q;
   logic sync_q;
   logic prev_q;
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end
      else
      begin
         meta_q <= ext_level;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end
   assign rise = sync_q & ~prev_q;
   assign fall = ~sync_q & prev_q;
endmodule // ext_clock_sync
`default_nettype wire

// ==== auto_reload_timer.sv ====
// Purpose: 16-bit or dual 8-bit auto-reload timer with capture.
// Assumes: Register bus is synchronous with one-cycle reads and writes.
// Notes:   ext_clk_div8 is the external oscillator already divided by 8.
//
// Summary of operation
// - 16-bit mode: wrap from FFFF loads reload value, sets high flag.
// - Split bit picks one 16-bit timer or two 8-bit timers.
// - Interrupt request whenever high flag set and timer interrupt enabled.
// - Low flag also requests interrupt when low interrupt enable set.
// - Split mode: each half reloads from its own reload byte.
// - Run bit gates whole timer, or only high half in split mode.
// - Half uses system clock if its select bit is 1, else shared source.
// - External select picks clock/12 when 0, external/8 when 1.
// - External divided clock is synchronised before advancing the count.
// - Low flag set whenever low byte wraps, in either mode.
// - Flags are cleared only by software writes, never by hardware.
// - Capture copies count into reload pair and sets high flag.
// - Capture enable bit switches capture off or on.
// - Control bit 1 reads zero and ignores writes.
// - High flag is bit 7, low flag is bit 6.
// - High flag with interrupt enabled vectors the processor.
// - High select bit only in split mode; low select drives 16-bit.
`timescale 1ns/1ps
`default_nettype none
module auto_reload_timer
   import timer_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Special function register bus
   input  wire logic [7:0] sfr_addr,
   input  wire logic [7:0] sfr_wdata,
   input  wire logic       sfr_we,
   input  wire logic       sfr_re,
   output var  logic [7:0] sfr_rdata,
   // Interrupt enable from the processor
   input  wire logic       timer_irq_enable_bit,
   // External oscillator divided by 8
   input  wire logic       ext_clk_div8,
   // Interrupt request
   output var  logic       timer_irq
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [7:0] count_low_byte;
   logic [7:0] count_high_byte;
   logic [7:0] reload_low_byte;
   logic [7:0] reload_high_byte;
   logic       high_overflow_flag;
   logic       low_overflow_flag;
   logic       low_overflow_irq_en;
   logic       capture_en;
   logic       split_mode_sel;
   logic       run_ctrl;
   logic       ext_source_sel;
   logic       high_half_system_clock_sel;
   logic       low_half_system_clock_sel;
   // ------------------------------------------------------------
   // Tick sources
   // ------------------------------------------------------------
   wire sys12_tick;
   wire ext_rise;
   wire ext_fall;
   tick_divider #(.DIV(sys_div)) u_div
   (
      .clk   (clk),
      .rst_n (rst_n),
      .tick  (sys12_tick)
   );
   ext_clock_sync u_sync
   (
      .clk       (clk),
      .rst_n     (rst_n),
      .ext_level (ext_clk_div8),
      .rise      (ext_rise),
      .fall      (ext_fall)
   );
   wire shared_tick = ext_source_sel ? ext_rise : sys12_tick;
   wire lo_tick = low_half_system_clock_sel ? 1'b1 : shared_tick;
   // high select counts only in split mode
   wire hi_src  = split_mode_sel
                  ? (high_half_system_clock_sel ? 1'b1 : shared_tick)
                  : lo_tick;
   // ------------------------------------------------------------
   // Count enables
   // ------------------------------------------------------------
   // run gating per mode
   wire lo_en  = split_mode_sel ? lo_tick : (lo_tick & run_ctrl);
   wire hi_en8 = run_ctrl & hi_src;
   wire lo_wrap = lo_en & (count_low_byte == 8'hFF);
   // mode decides how the high byte advances
   wire hi_step = split_mode_sel ? hi_en8 : lo_wrap;
   wire hi_wrap = hi_step & (count_high_byte == 8'hFF);
   wire capture = capture_en & ext_fall;
   // ------------------------------------------------------------
   // Register bus decode
   // ------------------------------------------------------------
   // Address match, shared by the write and the read decoders.
   function automatic logic addr_hit(input logic [7:0] a,
                                     input logic [7:0] o);
      addr_hit = (a == o);
   endfunction
   wire sel_ctrl = addr_hit(sfr_addr, ctrl_offset);
   wire sel_rll  = addr_hit(sfr_addr, reload_lo_offset);
   wire sel_rlh  = addr_hit(sfr_addr, reload_hi_offset);
   wire sel_cl   = addr_hit(sfr_addr, count_lo_offset);
   wire sel_ch   = addr_hit(sfr_addr, count_hi_offset);
   wire sel_ck   = addr_hit(sfr_addr, clkctl_offset);
   wire wr_ctrl  = sfr_we & sel_ctrl;
   wire wr_rll   = sfr_we & sel_rll;
   wire wr_rlh   = sfr_we & sel_rlh;
   wire wr_cl    = sfr_we & sel_cl;
   wire wr_ch    = sfr_we & sel_ch;
   wire wr_ck    = sfr_we & sel_ck;
   // ------------------------------------------------------------
   // Write data
   // ------------------------------------------------------------
   // bit 1 ignored on write
   // Masking keeps unused and reserved bits from ever being stored.
   wire [7:0] ctrl_wr = sfr_wdata & ctrl_wmask;
   wire [7:0] ck_wr   = sfr_wdata & clkctl_wmask;
   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   // bit 1 reads zero
   wire [7:0] ctrl_view = {high_overflow_flag, low_overflow_flag,
                           low_overflow_irq_en, capture_en,
                           split_mode_sel, run_ctrl, 1'b0,
                           ext_source_sel};
   wire [7:0] ck_view = {2'b00, high_half_system_clock_sel,
                         low_half_system_clock_sel, 4'h0};
   logic [7:0] rd_mux;
   always_comb
   begin
      if (sel_ctrl)
         rd_mux = ctrl_view;
      else if (sel_rll)
         rd_mux = reload_low_byte;
      else if (sel_rlh)
         rd_mux = reload_high_byte;
      else if (sel_cl)
         rd_mux = count_low_byte;
      else if (sel_ch)
         rd_mux = count_high_byte;
      else if (sel_ck)
         rd_mux = ck_view;
      else
         rd_mux = 8'h00;
   end
   // Idle reads return zero so a stale value never lingers on the bus.
   wire [7:0] rdata_d = sfr_re ? rd_mux : 8'h00;
   // ------------------------------------------------------------
   // Flag next values
   // ------------------------------------------------------------
   // only software clears; a set wins over a clear.
   wire hi_set = hi_wrap | capture;
   // low flag on every low-byte wrap
   wire lo_set = lo_wrap;
   // An overflow in the cycle of a clearing write is never lost.
   wire hi_keep   = wr_ctrl ? ctrl_wr[hi_flag_bit] : high_overflow_flag;
   wire lo_keep   = wr_ctrl ? ctrl_wr[lo_flag_bit] : low_overflow_flag;
   wire hi_flag_d = hi_keep | hi_set;
   wire lo_flag_d = lo_keep | lo_set;
   // ------------------------------------------------------------
   // Counter and reload next values
   // ------------------------------------------------------------
   // split low half reloads alone
   // 16-bit wrap loads the full reload value
   // A 16-bit reload waits until both bytes wrap together.
   wire       lo_reload = lo_wrap & (split_mode_sel | hi_wrap);
   wire [7:0] lo_inc    = count_low_byte + 8'h01;
   wire [7:0] hi_inc    = count_high_byte + 8'h01;
   // A bus write to a count byte takes priority over counting.
   wire [7:0] count_low_d  = wr_cl     ? sfr_wdata       :
                             lo_reload ? reload_low_byte :
                             lo_en     ? lo_inc          :
                                         count_low_byte;
   // high half reloads from its byte
   wire [7:0] count_high_d = wr_ch   ? sfr_wdata        :
                             hi_wrap ? reload_high_byte :
                             hi_step ? hi_inc           :
                                       count_high_byte;
   // capture copies the count
   // Capture wins over a software reload write in the same cycle.
   wire [7:0] reload_low_d  = capture ? count_low_byte  :
                              wr_rll  ? sfr_wdata       :
                                        reload_low_byte;
   wire [7:0] reload_high_d = capture ? count_high_byte :
                              wr_rlh  ? sfr_wdata       :
                                        reload_high_byte;
   // ------------------------------------------------------------
   // Flag registers
   // ------------------------------------------------------------
   // Flags drop only through a control write or reset.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         high_overflow_flag <= ctrl_reset[hi_flag_bit];
         low_overflow_flag  <= ctrl_reset[lo_flag_bit];
      end
      else
      begin
         high_overflow_flag <= hi_flag_d;
         low_overflow_flag  <= lo_flag_d;
      end
   end
   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         low_overflow_irq_en <= ctrl_reset[lo_irq_en_bit];
         capture_en          <= ctrl_reset[capture_en_bit];
         split_mode_sel      <= ctrl_reset[split_bit];
         run_ctrl            <= ctrl_reset[run_bit];
         ext_source_sel      <= ctrl_reset[ext_sel_bit];
      end
      else if (wr_ctrl)
      begin
         low_overflow_irq_en <= ctrl_wr[lo_irq_en_bit];
         capture_en          <= ctrl_wr[capture_en_bit];
         split_mode_sel      <= ctrl_wr[split_bit];
         run_ctrl            <= ctrl_wr[run_bit];
         ext_source_sel      <= ctrl_wr[ext_sel_bit];
      end
   end
   // ------------------------------------------------------------
   // Clock select register
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         high_half_system_clock_sel <= 1'b0;
         low_half_system_clock_sel  <= 1'b0;
      end
      else if (wr_ck)
      begin
         high_half_system_clock_sel <= ck_wr[hi_sys_bit];
         low_half_system_clock_sel  <= ck_wr[lo_sys_bit];
      end
   end
   // ------------------------------------------------------------
   // Counter and reload registers
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         count_low_byte   <= 8'h00;
         count_high_byte  <= 8'h00;
         reload_low_byte  <= reload_reset;
         reload_high_byte <= reload_reset;
      end
      else
      begin
         count_low_byte   <= count_low_d;
         count_high_byte  <= count_high_d;
         reload_low_byte  <= reload_low_d;
         reload_high_byte <= reload_high_d;
      end
   end
   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // high flag or enabled low flag request
   wire irq_d = timer_irq_enable_bit &
                (high_overflow_flag |
                 (low_overflow_irq_en & low_overflow_flag));
   // The request is registered so it never glitches with the decode.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         timer_irq <= 1'b0;
      else
         timer_irq <= irq_d;
   end
   // Read data is registered and valid one cycle after the read.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         sfr_rdata <= 8'h00;
      else
         sfr_rdata <= rdata_d;
   end
endmodule // auto_reload_timer
`default_nettype wire

// ==== cpu_model.sv ====
// Purpose: Processor core model driving the register bus.
// Assumes: Each access starts at the rising edge after the call.
// Notes:   A released bus shows inverted address and data with both strobes low, not the last values.
`timescale 1ns/1ps
`default_nettype none
module cpu_model
(
   // Clock
   input  wire logic       clk,
   // Register bus
   output var  logic [7:0] sfr_addr,
   output var  logic [7:0] sfr_wdata,
   output var  logic       sfr_we,
   output var  logic       sfr_re,
   input  wire logic [7:0] sfr_rdata
);
   initial {sfr_addr, sfr_wdata, sfr_we, sfr_re} = 18'h0;
   task automatic acc(input logic w, input logic [7:0] a, d,
                      output logic [7:0] q);
      @(posedge clk);
      #1 {sfr_addr, sfr_wdata, sfr_we, sfr_re} = {a, d, w, !w};
      @(posedge clk);
      #1 q = sfr_rdata;
      {sfr_addr, sfr_wdata, sfr_we, sfr_re} = {~a, ~d, 2'b00};
   endtask
endmodule // cpu_model
`default_nettype wire

// ==== timer_monitor.sv ====
// Purpose: Port checks for the auto-reload timer.
// Assumes: Registered read data, one cycle after the read edge.
// Notes:   Bound into every timer instance.
`timescale 1ns/1ps
`default_nettype none
module timer_monitor
(
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // Register bus and interrupt
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic       sfr_we,
   input wire logic       sfr_re,
   input wire logic [7:0] sfr_rdata,
   input wire logic       timer_irq_enable_bit,
   input wire logic       timer_irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_RD_IDLE:
   assert property (!sfr_re |=> sfr_rdata == 8'h00)
      else $error("read data not zero while idle");
   AST_RD_UNMAPPED:
   assert property (sfr_re && sfr_addr == 8'h00 |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_BIT1_ZERO:
   assert property (sfr_re && sfr_addr == 8'hC8 |=> !sfr_rdata[1])
      else $error("control bit 1 reads one");
   AST_CLKCTL_RD:
   assert property (sfr_re && sfr_addr == 8'h8E |=> !(|(sfr_rdata & 8'hCF)))
      else $error("clock select spare bits set");
   AST_IRQ_OFF:
   assert property (!timer_irq_enable_bit |=> !timer_irq)
      else $error("interrupt while disabled");
   AST_IRQ_FLAGS:
   assert property (sfr_re && sfr_addr == 8'hC8 && timer_irq_enable_bit
      |=> timer_irq == (sfr_rdata[7] | (sfr_rdata[6] & sfr_rdata[5])))
      else $error("interrupt disagrees with flags");
   AST_FLAGS_STICKY:
   assert property (sfr_re && sfr_addr == 8'hC8 && !sfr_we ##1 !sfr_we
      ##1 sfr_re && sfr_addr == 8'hC8 ##1 1'b1 |->
      (sfr_rdata[7:6] & $past(sfr_rdata[7:6], 2)) == $past(sfr_rdata[7:6], 2))
      else $error("flag cleared by hardware");
   AST_RELOAD_RW:
   assert property (sfr_we && sfr_addr == 8'hCB ##2 sfr_re && !sfr_we
      && sfr_addr == 8'hCB |=> sfr_rdata == $past(sfr_wdata, 3))
      else $error("reload high byte lost");
endmodule // timer_monitor
bind auto_reload_timer timer_monitor i_timer_monitor (.clk, .rst_n,
   .sfr_addr, .sfr_wdata, .sfr_we, .sfr_re, .sfr_rdata,
   .timer_irq_enable_bit, .timer_irq);
`default_nettype wire

// ==== auto_reload_timer_tb.sv ====
// Purpose: Self-checking bench for the auto-reload timer.
// Assumes: Reload values and counts are random from a fixed seed.
// Notes:   The external divided clock is toggled by the bench.
`timescale 1ns/1ps
`default_nettype none
module auto_reload_timer_tb;
   logic        clk, rst_n, irq_en, ext_clk, we, re, irq;
   logic [7:0]  addr, wdata, rdata;
   logic [15:0] r, c;
   int          err_count, check_count;
   cpu_model i_cpu_model (.clk(clk), .sfr_addr(addr), .sfr_wdata(wdata),
      .sfr_we(we), .sfr_re(re), .sfr_rdata(rdata));
   auto_reload_timer i_auto_reload_timer (.clk(clk), .rst_n(rst_n),
      .sfr_addr(addr), .sfr_wdata(wdata), .sfr_we(we), .sfr_re(re),
      .sfr_rdata(rdata), .timer_irq_enable_bit(irq_en),
      .ext_clk_div8(ext_clk), .timer_irq(irq));
   initial clk = 1'b0;
   always #12.5 clk = ~clk;
   task finish_test();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input string n, input logic [7:0] e, g);
      check_count++;
      if (g !== e)
      begin
         err_count++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   task wr(input logic [7:0] a, d);
      logic [7:0] q;
      i_cpu_model.acc(1'b1, a, d, q);
   endtask
   task rchk(input logic [7:0] a, e);
      logic [7:0] q;
      i_cpu_model.acc(1'b0, a, 8'h00, q);
      chk($sformatf("reg %h", a), e, q);
   endtask
   task poll(input int b);
      logic [7:0] q;
      int         n;
      q = 8'h00;
      for (n = 0; n < 300 && q[b] !== 1'b1; n++)
         i_cpu_model.acc(1'b0, 8'hC8, 8'h00, q);
      if (q[b] !== 1'b1)
      begin
         err_count++;
         finish_test();
      end
   endtask
   task ext_pulse();
      repeat (8) @(posedge clk);
      #1 ext_clk = 1'b1;
      repeat (8) @(posedge clk);
      #1 ext_clk = 1'b0;
      repeat (8) @(posedge clk);
   endtask
   initial
   begin
      {rst_n, irq_en, ext_clk, err_count, check_count} = '0;
      void'($urandom(32'h0AFF8643));
      repeat (8) @(posedge clk);
      #1 rst_n = 1'b1;
      rchk(8'hC8, 8'h00);
      rchk(8'hCA, 8'h00);
      rchk(8'hCB, 8'h00);
      rchk(8'h8E, 8'h00);
      rchk(8'h00, 8'h00);
      wr(8'hC8, 8'hFF);
      rchk(8'hC8, 8'hFD);
      wr(8'hC8, 8'h00);
      r = 16'($urandom);
      wr(8'hCA, r[7:0]);
      wr(8'hCB, r[15:8]);
      rchk(8'hCB, r[15:8]);
      rchk(8'hCA, r[7:0]);
      wr(8'h8E, 8'h20);
      wr(8'hCC, 8'hFE);
      wr(8'hCD, 8'hFF);
      irq_en = 1'b1;
      wr(8'hC8, 8'h04);
      poll(7);
      rchk(8'hCC, r[7:0]);
      rchk(8'hCD, r[15:8]);
      rchk(8'hC8, 8'hC4);
      chk("irq", 8'h01, {7'h00, irq});
      wr(8'hC8, 8'h00);
      c = 16'($urandom % 200);
      wr(8'h8E, 8'h00);
      wr(8'hCC, c[7:0]);
      wr(8'hC8, 8'h05);
      repeat (3) ext_pulse();
      wr(8'hC8, 8'h00);
      rchk(8'hCC, c[7:0] + 8'h03);
      c = 16'($urandom);
      wr(8'hCC, c[7:0]);
      wr(8'hCD, c[15:8]);
      wr(8'hC8, 8'h10);
      ext_pulse();
      poll(7);
      rchk(8'hCA, c[7:0]);
      rchk(8'hCB, c[15:8]);
      wr(8'hC8, 8'h00);
      ext_pulse();
      rchk(8'hC8, 8'h00);
      r = 16'($urandom);
      wr(8'hCA, r[7:0]);
      wr(8'hCB, r[15:8]);
      wr(8'hCC, 8'hFE);
      wr(8'hCD, 8'hFF);
      wr(8'hC8, 8'h08);
      poll(6);
      rchk(8'hCC, r[7:0]);
      rchk(8'hCD, 8'hFF);
      rchk(8'hC8, 8'h48);
      chk("irq", 8'h00, {7'h00, irq});
      wr(8'hC8, 8'h68);
      @(posedge clk);
      #1 chk("irq", 8'h01, {7'h00, irq});
      wr(8'hC8, 8'h0C);
      poll(7);
      rchk(8'hCD, r[15:8]);
      chk("irq", 8'h01, {7'h00, irq});
      wr(8'hC8, 8'h08);
      wr(8'h8E, 8'h10);
      c = 16'($urandom % 200);
      wr(8'hCC, c[7:0]);
      rchk(8'hCC, c[7:0] + 8'h01);
      wr(8'h8E, 8'h20);
      c = 16'($urandom % 200);
      wr(8'hCD, c[7:0]);
      wr(8'hC8, 8'h0C);
      rchk(8'hCD, c[7:0] + 8'h01);
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      rchk(8'hC8, 8'h00);
      rchk(8'h8E, 8'h00);
      rchk(8'hCD, 8'h00);
      chk("irq", 8'h00, {7'h00, irq});
      finish_test();
   end
endmodule // auto_reload_timer_tb
`default_nettype wire
